//--- hdl/tmc_timers.sv
`timescale 1ns/10ps
`include "tmc_consts.svh"
// Functional notes
// - mode 1 counts the full 16 bits of high and low byte
// - mode 2 counts in the low byte, high byte holds reload value
// - mode 2 low byte wrap sets overflow flag and reloads from high byte
// - mode 2 reload never modifies the high byte
// - timer runs on run bit, and gated by active irq input when gate set
// - mode 3 timer zero low byte uses timer zero controls and flag
// - mode 3 timer zero high byte only times, enabled by timer one run bit
// - mode 3 high byte overflow sets timer one overflow flag
// - with timer zero split, timer one counts no events, sets no flag
// - timer one mode 3 halts it; split timer zero lets modes 0-2 run
// - mode field: 13-bit, 16-bit, 8-bit reload, split or stop
// - overflow flags set by hardware, cleared by software or vectoring
// - source select one counts falling edges of the event pin
// - clock select picks system or prescaled clock; ignored as counter
// - prescaler divides by 12, 4, 48 or external clock by 8
// - external clock is synchronised; must stay below half the system clock
// - irq type bit: zero level triggered, one edge triggered
// - edge flag set on edge, cleared on vectoring; level flag follows input
// - third-timer clock select bits kept and driven out
// - unused clock-select bits read zero; all registers reset to zero
// - mode 0 counts 13 bits and overflows from 0x1FFF to zero
// - setting the run bit keeps the current count
module tmc_timers #(
  parameter int EXT_DIV = `TMC_EXT_DIV // external clock divisor
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire tmc_pkg::tmc_sfr_req_t sfr_req, // register access request
  output logic [7:0] sfr_rdata, // read data, one cycle after rd
  input wire tmc_pkg::tmc_vector_ack_t vector_ack, // processor vectored, pulses
  input wire logic t0_event_pin, // timer zero event input
  input wire logic t1_event_pin, // timer one event input
  input wire logic ext_irq0_input, // external interrupt zero pin
  input wire logic ext_irq1_input, // external interrupt one pin
  input wire logic ext_irq0_polarity, // 1 = input active high
  input wire logic ext_irq1_polarity, // 1 = input active high
  input wire logic ext_clk, // external oscillator clock, sampled
  output logic t0_irq_req, // timer zero overflow flag
  output logic t1_irq_req, // timer one overflow flag
  output logic ext_irq0_req, // external interrupt zero flag
  output logic ext_irq1_req, // external interrupt one flag
  output logic t0_ovf_pulse, // timer zero overflow pulse
  output logic t1_ovf_pulse, // timer one overflow pulse, baud and converter
  output logic tmr_c_high_clock_select, // third timer high byte clock select
  output logic tmr_c_low_clock_select // third timer low byte clock select
);
  import tmc_pkg::*;

  // ==========================================
  // parameter check
  // the divider wraps its counter freely, so only powers of two from 2 up divide evenly
  if (EXT_DIV < 2 || (EXT_DIV & (EXT_DIV - 1)) != 0) begin : g_bad_ext_div
    $error("EXT_DIV must be a power of two of at least 2");
  end

  // ==========================================
  // reset release
  logic rst_meta_q, rst_sync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================
  // registers
  logic [7:0] run_flags_q, mode_sel_q, clk_sel_q;
  logic [7:0] t0_low_byte, t0_high_byte, t1_low_byte, t1_high_byte;
  logic wr_rf, wr_ms, wr_cs, wr_t0l, wr_t0h, wr_t1l, wr_t1h;
  assign wr_rf = sfr_req.wr && sfr_req.addr == `TMC_ADDR_RUN_FLAGS;
  assign wr_ms = sfr_req.wr && sfr_req.addr == `TMC_ADDR_MODE_SEL;
  assign wr_cs = sfr_req.wr && sfr_req.addr == `TMC_ADDR_CLK_SEL;
  assign wr_t0l = sfr_req.wr && sfr_req.addr == `TMC_ADDR_T0_LOW;
  assign wr_t0h = sfr_req.wr && sfr_req.addr == `TMC_ADDR_T0_HIGH;
  assign wr_t1l = sfr_req.wr && sfr_req.addr == `TMC_ADDR_T1_LOW;
  assign wr_t1h = sfr_req.wr && sfr_req.addr == `TMC_ADDR_T1_HIGH;

  tmc_mode_t t0_mode_field, t1_mode_field;
  tmc_scale_t prescale_field;
  logic t0_run, t1_run, t0_gate_enable, t1_gate_enable;
  logic t0_source_select, t1_source_select, t0_clock_select, t1_clock_select;
  logic ext_irq0_type, ext_irq1_type;
  assign t0_mode_field = tmc_mode_t'(mode_sel_q[`TMC_MS_T0_MODE_LSB +: 2]);
  assign t1_mode_field = tmc_mode_t'(mode_sel_q[`TMC_MS_T1_MODE_LSB +: 2]);
  assign prescale_field = tmc_scale_t'(clk_sel_q[`TMC_CS_SCALE_LSB +: 2]);
  assign t0_run = run_flags_q[`TMC_RF_T0_RUN];
  assign t1_run = run_flags_q[`TMC_RF_T1_RUN];
  assign t0_gate_enable = mode_sel_q[`TMC_MS_T0_GATE];
  assign t1_gate_enable = mode_sel_q[`TMC_MS_T1_GATE];
  assign t0_source_select = mode_sel_q[`TMC_MS_T0_SRC];
  assign t1_source_select = mode_sel_q[`TMC_MS_T1_SRC];
  assign t0_clock_select = clk_sel_q[`TMC_CS_T0_CLK];
  assign t1_clock_select = clk_sel_q[`TMC_CS_T1_CLK];
  assign ext_irq0_type = run_flags_q[`TMC_RF_IRQ0_TYPE];
  assign ext_irq1_type = run_flags_q[`TMC_RF_IRQ1_TYPE];

  // ==========================================
  // prescaler
  logic [5:0] div_cnt_q, div_limit;
  logic div_tick, presc_tick;
  always_comb begin
    case (prescale_field)
      TMC_SCALE_DIV12: div_limit = `TMC_DIV_BY12;
      TMC_SCALE_DIV4: div_limit = `TMC_DIV_BY4;
      TMC_SCALE_DIV48: div_limit = `TMC_DIV_BY48;
      default: div_limit = `TMC_DIV_BY12;
    endcase
  end
  assign div_tick = (div_cnt_q >= div_limit - 6'h01);
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt_q <= 6'h00;
    end else if (div_tick) begin
      div_cnt_q <= 6'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // external clock: sampled, so it must stay below half the system clock
  logic ext_meta_q, ext_sync_q, ext_prev_q, ext_tick;
  logic [$clog2(EXT_DIV)-1:0] ext_cnt_q;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_cnt_q <= '0;
    end else begin
      ext_meta_q <= ext_clk;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      if (ext_sync_q && !ext_prev_q) begin
        ext_cnt_q <= ext_cnt_q + 1'b1;
      end
    end
  end
  assign ext_tick = ext_sync_q && !ext_prev_q && (&ext_cnt_q);
  assign presc_tick = (prescale_field == TMC_SCALE_EXT8) ? ext_tick : div_tick;

  // ==========================================
  // event pin and interrupt input sampling
  logic ev0_prev_q, ev1_prev_q, ev0_fall, ev1_fall;
  logic irq0_prev_q, irq1_prev_q, irq0_active, irq1_active;
  // pins are taken as synchronous; one previous sample is enough to find an edge
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ev0_prev_q <= 1'b0;
      ev1_prev_q <= 1'b0;
    end else begin
      ev0_prev_q <= t0_event_pin;
      ev1_prev_q <= t1_event_pin;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq0_prev_q <= 1'b0;
      irq1_prev_q <= 1'b0;
    end else begin
      irq0_prev_q <= irq0_active;
      irq1_prev_q <= irq1_active;
    end
  end
  assign ev0_fall = ev0_prev_q && !t0_event_pin;
  assign ev1_fall = ev1_prev_q && !t1_event_pin;
  assign irq0_active = (ext_irq0_input == ext_irq0_polarity);
  assign irq1_active = (ext_irq1_input == ext_irq1_polarity);

  // ==========================================
  // count step for modes 0 to 2, returns {overflow, high, low}
  function automatic logic [16:0] tmc_step(input tmc_mode_t m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [12:0] s13;
    logic [15:0] s16;
    s13 = {hi, lo[4:0]} + 13'h0001;
    s16 = {hi, lo} + 16'h0001;
    case (m)
      TMC_MODE_13BIT: tmc_step = {&{hi, lo[4:0]}, s13[12:5], lo[7:5], s13[4:0]};
      TMC_MODE_16BIT: tmc_step = {&{hi, lo}, s16};
      TMC_MODE_RELOAD8: tmc_step = {&lo, hi, (&lo) ? hi : lo + 8'h01};
      default: tmc_step = {1'b0, hi, lo};
    endcase
  endfunction

  // ==========================================
  // tick selection and next counts
  logic t0_split, t0_enable, t1_enable, t0h_enable;
  logic t0_tick, t1_tick, t0h_tick;
  logic [16:0] t0_res, t1_res;
  logic t0_ovf, t1_ovf, t0h_ovf;
  logic [7:0] t0l_nxt, t0h_nxt;
  assign t0_split = (t0_mode_field == TMC_MODE_SPLIT);
  assign t0_enable = t0_run && (!t0_gate_enable || irq0_active);
  // split timer zero takes over timer one's run bit; timer one then runs on mode alone
  assign t1_enable = (t1_mode_field != TMC_MODE_SPLIT) &&
                     (t0_split || (t1_run && (!t1_gate_enable || irq1_active)));
  assign t0h_enable = t0_split && t1_run;
  assign t0_tick = t0_enable && (t0_source_select ? ev0_fall :
                   (t0_clock_select || presc_tick));
  assign t1_tick = t1_enable && ((t1_source_select && !t0_split) ? ev1_fall :
                   (t1_clock_select || presc_tick));
  // high half of split timer zero borrows timer one's clock select
  assign t0h_tick = t0h_enable && (t1_clock_select || presc_tick);
  assign t0_res = tmc_step(t0_mode_field, t0_low_byte, t0_high_byte);
  assign t1_res = tmc_step(t1_mode_field, t1_low_byte, t1_high_byte);
  always_comb begin
    if (t0_split) begin
      t0_ovf = t0_tick && (&t0_low_byte);
      t0l_nxt = t0_tick ? t0_low_byte + 8'h01 : t0_low_byte;
      t0h_ovf = t0h_tick && (&t0_high_byte);
      t0h_nxt = t0h_tick ? t0_high_byte + 8'h01 : t0_high_byte;
    end else begin
      t0_ovf = t0_tick && t0_res[16];
      t0l_nxt = t0_tick ? t0_res[7:0] : t0_low_byte;
      t0h_ovf = 1'b0;
      t0h_nxt = t0_tick ? t0_res[15:8] : t0_high_byte;
    end
  end
  assign t1_ovf = t1_tick && t1_res[16];

  // a bus write to a count byte wins over counting in the same cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t0_low_byte <= `TMC_RESET_VAL;
      t0_high_byte <= `TMC_RESET_VAL;
    end else begin
      t0_low_byte <= wr_t0l ? sfr_req.wdata : t0l_nxt;
      t0_high_byte <= wr_t0h ? sfr_req.wdata : t0h_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t1_low_byte <= `TMC_RESET_VAL;
      t1_high_byte <= `TMC_RESET_VAL;
    end else begin
      t1_low_byte <= wr_t1l ? sfr_req.wdata : (t1_tick ? t1_res[7:0] : t1_low_byte);
      t1_high_byte <= wr_t1h ? sfr_req.wdata : (t1_tick ? t1_res[15:8] : t1_high_byte);
    end
  end

  // ==========================================
  // control registers and flags; hardware set wins over any clear
  logic t0_flag_set, t1_flag_set, irq0_edge, irq1_edge;
  logic [7:0] rf_base;
  assign t0_flag_set = t0_ovf;
  assign t1_flag_set = t0_split ? t0h_ovf : t1_ovf;
  assign irq0_edge = irq0_active && !irq0_prev_q;
  assign irq1_edge = irq1_active && !irq1_prev_q;
  always_comb begin
    rf_base = wr_rf ? sfr_req.wdata : run_flags_q;
    if (!wr_rf) begin
      rf_base[`TMC_RF_T0_OVF] = run_flags_q[`TMC_RF_T0_OVF] && !vector_ack.t0;
      rf_base[`TMC_RF_T1_OVF] = run_flags_q[`TMC_RF_T1_OVF] && !vector_ack.t1;
      rf_base[`TMC_RF_IRQ0_FLAG] = run_flags_q[`TMC_RF_IRQ0_FLAG] && !vector_ack.irq0;
      rf_base[`TMC_RF_IRQ1_FLAG] = run_flags_q[`TMC_RF_IRQ1_FLAG] && !vector_ack.irq1;
    end
    rf_base[`TMC_RF_T0_OVF] = rf_base[`TMC_RF_T0_OVF] || t0_flag_set;
    rf_base[`TMC_RF_T1_OVF] = rf_base[`TMC_RF_T1_OVF] || t1_flag_set;
    // level mode: flag mirrors the active level, so writes do not stick
    rf_base[`TMC_RF_IRQ0_FLAG] = ext_irq0_type ?
      (rf_base[`TMC_RF_IRQ0_FLAG] || irq0_edge) : irq0_active;
    rf_base[`TMC_RF_IRQ1_FLAG] = ext_irq1_type ?
      (rf_base[`TMC_RF_IRQ1_FLAG] || irq1_edge) : irq1_active;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      run_flags_q <= `TMC_RESET_VAL;
    end else begin
      run_flags_q <= rf_base;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_sel_q <= `TMC_RESET_VAL;
    end else if (wr_ms) begin
      mode_sel_q <= sfr_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_sel_q <= `TMC_RESET_VAL;
    end else if (wr_cs) begin
      clk_sel_q <= sfr_req.wdata & `TMC_CS_MASK;
    end
  end

  // ==========================================
  // read data and outputs
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        `TMC_ADDR_RUN_FLAGS: sfr_rdata <= run_flags_q;
        `TMC_ADDR_MODE_SEL: sfr_rdata <= mode_sel_q;
        `TMC_ADDR_CLK_SEL: sfr_rdata <= clk_sel_q;
        `TMC_ADDR_T0_LOW: sfr_rdata <= t0_low_byte;
        `TMC_ADDR_T0_HIGH: sfr_rdata <= t0_high_byte;
        `TMC_ADDR_T1_LOW: sfr_rdata <= t1_low_byte;
        `TMC_ADDR_T1_HIGH: sfr_rdata <= t1_high_byte;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // pulses feed baud and converter logic outside, so each stands one cycle per overflow
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t0_ovf_pulse <= 1'b0;
    end else begin
      t0_ovf_pulse <= t0_ovf;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t1_ovf_pulse <= 1'b0;
    end else begin
      t1_ovf_pulse <= t1_ovf;
    end
  end

  assign t0_irq_req = run_flags_q[`TMC_RF_T0_OVF];
  assign t1_irq_req = run_flags_q[`TMC_RF_T1_OVF];
  assign ext_irq0_req = run_flags_q[`TMC_RF_IRQ0_FLAG];
  assign ext_irq1_req = run_flags_q[`TMC_RF_IRQ1_FLAG];
  assign tmr_c_high_clock_select = clk_sel_q[`TMC_CS_C_HIGH];
  assign tmr_c_low_clock_select = clk_sel_q[`TMC_CS_C_LOW];
endmodule

//--- hdl/tmc_consts.svh
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
// ==========================================
// register addresses on the special-function bus
`define TMC_ADDR_RUN_FLAGS 8'h88
`define TMC_ADDR_MODE_SEL 8'h89
`define TMC_ADDR_T0_LOW 8'h8A
`define TMC_ADDR_T1_LOW 8'h8B
`define TMC_ADDR_T0_HIGH 8'h8C
`define TMC_ADDR_T1_HIGH 8'h8D
`define TMC_ADDR_CLK_SEL 8'h8E
`define TMC_RESET_VAL 8'h00
// ==========================================
// run/flags register bits
`define TMC_RF_T1_OVF 7
`define TMC_RF_T1_RUN 6
`define TMC_RF_T0_OVF 5
`define TMC_RF_T0_RUN 4
`define TMC_RF_IRQ1_FLAG 3
`define TMC_RF_IRQ1_TYPE 2
`define TMC_RF_IRQ0_FLAG 1
`define TMC_RF_IRQ0_TYPE 0
// ==========================================
// mode register bits
`define TMC_MS_T1_GATE 7
`define TMC_MS_T1_SRC 6
`define TMC_MS_T1_MODE_LSB 4
`define TMC_MS_T0_GATE 3
`define TMC_MS_T0_SRC 2
`define TMC_MS_T0_MODE_LSB 0
// ==========================================
// clock select register bits and writable mask
`define TMC_CS_C_HIGH 6
`define TMC_CS_C_LOW 5
`define TMC_CS_T1_CLK 4
`define TMC_CS_T0_CLK 3
`define TMC_CS_SCALE_LSB 0
`define TMC_CS_MASK 8'h7B
// ==========================================
// prescaler divisors
`define TMC_DIV_BY12 6'h0C
`define TMC_DIV_BY4 6'h04
`define TMC_DIV_BY48 6'h30
`define TMC_EXT_DIV 8
`endif

//--- hdl/tmc_pkg.sv
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_MODE_13BIT = 2'b00,
    TMC_MODE_16BIT = 2'b01,
    TMC_MODE_RELOAD8 = 2'b10,
    TMC_MODE_SPLIT = 2'b11
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_SCALE_DIV12 = 2'b00,
    TMC_SCALE_DIV4 = 2'b01,
    TMC_SCALE_DIV48 = 2'b10,
    TMC_SCALE_EXT8 = 2'b11
  } tmc_scale_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tmc_sfr_req_t;

  typedef struct packed {
    logic t0;
    logic t1;
    logic irq0;
    logic irq1;
  } tmc_vector_ack_t;
endpackage

//--- bench/tmc_timers_props.sv
`timescale 1ns/10ps
// ====================
// port checker
module tmc_timers_props (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire tmc_pkg::tmc_sfr_req_t sfr_req, // register request
  input wire logic [7:0] sfr_rdata, // read data
  input wire tmc_pkg::tmc_vector_ack_t vector_ack, // vectoring pulses
  input wire logic ext_irq0_input, // irq pin zero
  input wire logic ext_irq0_polarity, // irq zero polarity
  input wire logic t0_irq_req, // timer zero flag
  input wire logic t1_irq_req, // timer one flag
  input wire logic ext_irq0_req, // irq zero flag
  input wire logic t0_ovf_pulse, // timer zero pulse
  input wire logic t1_ovf_pulse, // timer one pulse
  input wire logic tmr_c_high_clock_select, // third timer select
  input wire logic tmr_c_low_clock_select // third timer select
);
  import tmc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_pulse_flag; t0_ovf_pulse |-> t0_irq_req; endproperty
  a_pulse_flag: assert property (p_pulse_flag) else $error("pulse without flag");
  property p_flag_pulse; $rose(t0_irq_req) && !$past(sfr_req.wr) |-> t0_ovf_pulse; endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag without pulse");
  property p_ack_clear; vector_ack.t0 |=> !t0_irq_req || t0_ovf_pulse; endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");
  property p_irq_rise;
    $rose(ext_irq0_req) |-> $past(ext_irq0_input) == $past(ext_irq0_polarity) || $past(sfr_req.wr);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq flag without cause");
  property p_unmapped;
    sfr_req.rd && (sfr_req.addr < 8'h88 || sfr_req.addr > 8'h8E) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ck_unused;
    sfr_req.rd && sfr_req.addr == 8'h8E |=> sfr_rdata[7] == 1'b0 && sfr_rdata[2] == 1'b0;
  endproperty
  a_ck_unused: assert property (p_ck_unused) else $error("unused bit reads one");
  property p_c_sel;
    sfr_req.wr && sfr_req.addr == 8'h8E |=> tmr_c_high_clock_select == $past(sfr_req.wdata[6])
      && tmr_c_low_clock_select == $past(sfr_req.wdata[5]);
  endproperty
  a_c_sel: assert property (p_c_sel) else $error("third timer select wrong");
  property p_c_hold;
    !(sfr_req.wr && sfr_req.addr == 8'h8E) |=> $stable({tmr_c_high_clock_select,
      tmr_c_low_clock_select});
  endproperty
  a_c_hold: assert property (p_c_hold) else $error("third timer select moved");
  c_t0_pulse: cover property (t0_ovf_pulse);
  c_t1_pulse: cover property (t1_ovf_pulse && !t1_irq_req);
  c_irq0: cover property ($rose(ext_irq0_req));
endmodule

bind tmc_timers tmc_timers_props tmc_timers_props_inst (.sys_clk, .rst_n, .sfr_req, .sfr_rdata,
  .vector_ack, .ext_irq0_input, .ext_irq0_polarity, .t0_irq_req, .t1_irq_req, .ext_irq0_req,
  .t0_ovf_pulse, .t1_ovf_pulse, .tmr_c_high_clock_select, .tmr_c_low_clock_select);

//--- bench/tmc_pin_model.sv
`timescale 1ns/10ps
// ====================
// event pins and external oscillator
module tmc_pin_model (
  input wire logic sys_clk, // system clock
  output logic t0_event_pin, // event pin zero
  output logic t1_event_pin, // event pin one
  output logic ext_clk // free-running oscillator
);
  logic [1:0] ev;
  assign t0_event_pin = ev[0];
  assign t1_event_pin = ev[1];
  initial begin
    ev = 2'h3;
    ext_clk = 1'b0;
    #7;
    forever #80 ext_clk = ~ext_clk; // slower than the system clock
  end
  // hold of two gives one event per five clocks, a fifth of the clock rate
  task automatic events(input int t, input int n, input int hold);
    repeat (n) begin
      @(posedge sys_clk) ev[t] <= 1'b0;
      repeat (hold) @(posedge sys_clk);
      ev[t] <= 1'b1;
      repeat (hold) @(posedge sys_clk);
    end
  endtask
endmodule

//--- bench/dual_timer_counter_modes_test.sv
`timescale 1ns/10ps
// ====================
// timer block bench
module dual_timer_counter_modes_test;
  import tmc_pkg::*;
  logic sys_clk, rst_n, ext_irq0_input, ext_irq1_input, ext_irq0_polarity, ext_irq1_polarity;
  logic t0_event_pin, t1_event_pin, ext_clk, t0_irq_req, t1_irq_req, ext_irq0_req;
  logic ext_irq1_req, t0_ovf_pulse, t1_ovf_pulse;
  logic tmr_c_high_clock_select, tmr_c_low_clock_select, e_f;
  logic [7:0] sfr_rdata, lo, hi, e_lo, e_hi;
  tmc_sfr_req_t sfr_req;
  tmc_vector_ack_t vector_ack;
  int errors, n_checks, seed, t, m, n, g;
  logic [7:0] cs_tab [5] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h03};
  int g_min [5] = '{1, 12, 4, 48, 25};
  int g_max [5] = '{1, 12, 4, 48, 26};
  tmc_timers tmc_timers_inst (.sys_clk, .rst_n, .sfr_req, .sfr_rdata, .vector_ack, .t0_event_pin,
    .t1_event_pin, .ext_irq0_input, .ext_irq1_input, .ext_irq0_polarity, .ext_irq1_polarity,
    .ext_clk, .t0_irq_req, .t1_irq_req, .ext_irq0_req, .ext_irq1_req, .t0_ovf_pulse,
    .t1_ovf_pulse, .tmr_c_high_clock_select, .tmr_c_low_clock_select);
  tmc_pin_model tmc_pin_model_inst (.sys_clk, .t0_event_pin, .t1_event_pin, .ext_clk);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string s, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) sfr_req <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk) sfr_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string s);
    @(posedge sys_clk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk) sfr_req <= '0;
    @(negedge sys_clk) check(s, sfr_rdata, exp);
  endtask
  // cycles from one overflow pulse to the next; the watchdog bounds the first wait
  task automatic gap(input int t, output int g);
    g = 0;
    @(negedge sys_clk);
    while ((t ? t1_ovf_pulse : t0_ovf_pulse) !== 1'b1) @(negedge sys_clk);
    do begin
      @(negedge sys_clk);
      g++;
    end while ((t ? t1_ovf_pulse : t0_ovf_pulse) !== 1'b1 && g < 300);
  endtask
  // expected count after n events: {flag, high, low}
  function automatic logic [16:0] model(input int m, input logic [15:0] v, input int n);
    logic f;
    logic [16:0] w;
    f = 1'b0;
    repeat (n) begin
      w = (m == 0) ? {4'h0, v[15:8], v[4:0]} + 17'h1 : {1'b0, v} + 17'h1;
      if (m == 0) begin
        f |= w[13];
        {v[15:8], v[4:0]} = w[12:0];
      end else if (m == 1) begin
        f |= w[16];
        v = w[15:0];
      end else begin
        f |= (v[7:0] == 8'hFF);
        v[7:0] = (v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h1;
      end
    end
    return {f, v};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    end_sim;
  end
  initial begin
    seed = 32'hF0A04624;
    rst_n = 1'b0;
    sfr_req = '0;
    vector_ack = '0;
    {ext_irq0_input, ext_irq1_input, ext_irq0_polarity, ext_irq1_polarity} = 4'h3;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int a = 8'h88; a <= 8'h8F; a++) rd(a[7:0], 8'h00, "reset value");
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h7B, "clock select");
    check("third timer selects", {tmr_c_high_clock_select, tmr_c_low_clock_select}, 2'h3);
    for (int k = 0; k < 12; k++) begin
      t = k % 2;
      m = (k / 2) % 3;
      lo = $random(seed);
      hi = $random(seed);
      n = 1 + ($random(seed) & 3);
      if (k < 6) begin
        lo = 8'hFE;
        n = 3;
        if (m != 2) hi = 8'hFF;
      end
      {e_f, e_hi, e_lo} = model(m, {hi, lo}, n);
      wr(8'h89, 8'((4 | m) << (4 * t)));
      wr(8'(8'h8A + t), lo);
      wr(8'(8'h8C + t), hi);
      wr(8'h88, 8'(8'h10 << (2 * t)));
      tmc_pin_model_inst.events(t, n, 2 + k % 2);
      rd(8'h88, 8'({e_f, 1'b1}) << (4 + 2 * t), "run and flag");
      wr(8'h88, 8'h00);
      rd(8'(8'h8A + t), e_lo, "low byte");
      rd(8'(8'h8C + t), e_hi, "high byte");
    end
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    tmc_pin_model_inst.events(0, 2, 3);
    ext_irq0_input <= 1'b1;
    tmc_pin_model_inst.events(0, 2, 3);
    @(negedge sys_clk) check("level irq flag", ext_irq0_req, 1'b1);
    rd(8'h8A, 8'h02, "gated count");
    @(posedge sys_clk) ext_irq0_input <= 1'b0;
    wr(8'h88, 8'h01);
    repeat (3) @(posedge sys_clk);
    check("edge irq flag clear", ext_irq0_req, 1'b0);
    ext_irq0_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ext_irq0_input <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("edge irq flag held", ext_irq0_req, 1'b1);
    vector_ack.irq0 <= 1'b1;
    @(posedge sys_clk) vector_ack.irq0 <= 1'b0;
    @(negedge sys_clk) check("edge irq flag acked", ext_irq0_req, 1'b0);
    @(posedge sys_clk) ext_irq1_polarity <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("low polarity irq flag", ext_irq1_req, 1'b1);
    wr(8'h8E, 8'h10);
    wr(8'h89, 8'h37);
    wr(8'h8B, 8'h5A);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hF0);
    wr(8'h88, 8'h50);
    tmc_pin_model_inst.events(0, 1, 2);
    repeat (20) @(posedge sys_clk);
    check("split high sets t1 flag", t1_irq_req, 1'b1);
    check("split low sets t0 flag", t0_irq_req, 1'b1);
    rd(8'h8B, 8'h5A, "halted timer one");
    rd(8'h8A, 8'h00, "split low byte");
    @(posedge sys_clk) vector_ack.t0 <= 1'b1;
    @(posedge sys_clk) vector_ack.t0 <= 1'b0;
    @(negedge sys_clk) check("t0 flag acked", t0_irq_req, 1'b0);
    wr(8'h88, 8'h00);
    wr(8'h8B, 8'hF0);
    wr(8'h8D, 8'hFF);
    wr(8'h89, 8'h57);
    gap(1, g);
    check("t1 flag stays clear", t1_irq_req, 1'b0);
    wr(8'h89, 8'h32);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    foreach (cs_tab[i]) begin
      wr(8'h8E, cs_tab[i]);
      gap(0, g);
      gap(0, g);
      check("prescale gap", g >= g_min[i] && g <= g_max[i], 1'b1);
    end
    end_sim;
  end
endmodule
